// ==== pkg/ctc_pkg.sv ====
// Constants, types and decode helpers shared by the compact timer compare core.
// Notes on behaviour
// - Period compare hits counter bits nine to seven.
// - Period setting zero lets counter overflow.
// - Mode field decodes compare, undefined, PWM, timer.
// - Compare A match applies hold, low, high, toggle.
// - PWM output function is inactive, active, wave.
// - Requested level equal to level leaves pin.
// - Timer on rising edge restores initial level, except in PWM.
// - Initial level bit sets start or active level.
// - Invert bit inverts pin, unused in timer mode.
// - Swap bit exchanges period and duty compares.
// - Clear select picks compare A or P clear, except in PWM.
// - Clear select low raises both match flags.
// - Clear select high never raises P flag outside PWM.
// - Compare A zero overflows without A flag.
// - In compare mode, of the two matches only compare A moves the pin.
// - On rising edge clears counter, falling keeps it.
// - Pause holds counter and resumes from it.
package ctc_pkg;
   localparam int CTC_CNT_W = 10;
   localparam int CTC_PER_W = 3;
   localparam int CTC_PER_POS = 7;
   localparam int CTC_PINS = 3;
   localparam logic [CTC_CNT_W-1:0] CTC_CNT_MAX = 10'h3ff;
   localparam logic [CTC_CNT_W:0] CTC_FULL_LEN = 11'h400;
   localparam logic [7:0] CTC_ADDR_CTRL1 = 8'h00;
   localparam logic [7:0] CTC_ADDR_CTRL2 = 8'h04;
   localparam logic [7:0] CTC_ADDR_CMPA = 8'h08;
   localparam logic [7:0] CTC_ADDR_CNT = 8'h0c;
   localparam logic [7:0] CTC_ADDR_FLAG = 8'h10;
   localparam logic [7:0] CTC_ADDR_PINEN = 8'h14;
   localparam int CTC_PAUSE_BIT = 7;
   localparam int CTC_ON_BIT = 3;
   localparam int CTC_PER_LSB = 0;
   localparam int CTC_MODE_LSB = 6;
   localparam int CTC_IO_LSB = 4;
   localparam int CTC_OC_BIT = 3;
   localparam int CTC_POL_BIT = 2;
   localparam int CTC_SWAP_BIT = 1;
   localparam int CTC_CLR_BIT = 0;
   localparam int CTC_FLAG_A_BIT = 0;
   localparam int CTC_FLAG_P_BIT = 1;
   localparam logic [7:0] CTC_CTRL_RST = 8'h00;
   localparam logic [CTC_CNT_W-1:0] CTC_CMPA_RST = 10'h000;
   localparam logic [CTC_PINS-1:0] CTC_PINEN_RST = 3'h0;
   typedef enum logic [1:0]
   {
      CTC_MODE_CMP = 2'h0,
      CTC_MODE_UNDEF = 2'h1,
      CTC_MODE_TC = 2'h3,
      CTC_MODE_PWM = 2'h2
   } ctc_mode_t;
   typedef enum logic [1:0]
   {
      CTC_IO_HOLD = 2'h0,
      CTC_IO_LOW = 2'h1,
      CTC_IO_HIGH = 2'h2,
      CTC_IO_TOGGLE = 2'h3
   } ctc_io_t;
   localparam logic [1:0] CTC_PWM_INACT = 2'h0;
   localparam logic [1:0] CTC_PWM_ACT = 2'h1;
   localparam logic [1:0] CTC_PWM_WAVE = 2'h2;

   // True where the output pins are driven by the timer.
   function automatic logic ctc_pin_mode(input ctc_mode_t m);
      return (m == CTC_MODE_CMP) || (m == CTC_MODE_PWM);
   endfunction

   // True when a bus address selects the given register.
   function automatic logic ctc_hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction
endpackage

// ==== pkg/ctc_cmp_if.sv ====
// Carrier between the timer core and its comparator block.
`timescale 1ns/1ns
interface ctc_cmp_if;
   import ctc_pkg::*;
   logic [CTC_CNT_W-1:0] cnt;
   logic [CTC_PER_W-1:0] per;
   logic [CTC_CNT_W-1:0] cmpa;
   logic a_hit;
   logic p_hit;
   logic ovf;
   modport core (output cnt, output per, output cmpa, input a_hit, input p_hit, input ovf);
   modport cmp (input cnt, input per, input cmpa, output a_hit, output p_hit, output ovf);
endinterface

// ==== hdl/ctc_cmp.sv ====
// Comparators A and P, judged on the count the next tick would reach.
`timescale 1ns/1ns
module ctc_cmp
   import ctc_pkg::*;
(
   ctc_cmp_if.cmp cif
);
   logic [CTC_CNT_W-1:0] nxt;

   assign nxt = cif.cnt + 10'h001;
   // A zero compare value never matches, so the counter runs to overflow.
   assign cif.a_hit = (cif.cmpa != CTC_CMPA_RST) && (nxt == cif.cmpa);
   // The period bits form the top three bits of the value, with the low seven zero, giving 128-tick steps.
   assign cif.p_hit = (cif.per != 3'h0) && (nxt == {cif.per, 7'h00});
   assign cif.ovf = cif.cnt == CTC_CNT_MAX;
endmodule

// ==== hdl/ctc_top.sv ====
// Compact timer with compare-match and PWM output control and an APB register slave.
`timescale 1ns/1ns
module ctc_top
   import ctc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer_tick,
   output logic timer_out_pin_zero,
   output logic timer_out_pin_one,
   output logic timer_out_pin_two
);
   logic [7:0] ctrl1_q;
   logic [7:0] timer_control_two_q;
   logic [CTC_CNT_W-1:0] cmpa_q;
   logic [CTC_PINS-1:0] pinen_q;
   logic [CTC_CNT_W-1:0] cnt_q;
   logic [CTC_CNT_W-1:0] cnt_d;
   logic flag_a_q;
   logic flag_p_q;
   logic on_prev_q;
   logic lvl_q;
   logic lvl_d;
   logic [CTC_PINS-1:0] pin_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic acc;
   logic wr_fire;
   logic mapped;
   logic [31:0] rd_val;
   logic timer_on;
   logic counter_pause;
   logic [CTC_PER_W-1:0] period_compare_bits;
   ctc_mode_t mode_field;
   logic [1:0] output_function_field;
   logic output_initial_level;
   logic output_invert;
   logic period_duty_swap;
   logic clear_source_select;
   logic is_pwm;
   logic on_rise;
   logic run;
   logic clear_by_a;
   logic a_evt;
   logic p_evt;
   logic clear_evt;
   logic [CTC_CNT_W:0] per_len;
   logic [CTC_CNT_W:0] duty;

   ctc_cmp_if cif();

   ctc_cmp u_cmp
   (
      .cif(cif)
   );

   assign cif.cnt = cnt_q;
   assign cif.per = period_compare_bits;
   assign cif.cmpa = cmpa_q;

   assign timer_on = ctrl1_q[CTC_ON_BIT];
   assign counter_pause = ctrl1_q[CTC_PAUSE_BIT];
   assign period_compare_bits = ctrl1_q[CTC_PER_LSB +: CTC_PER_W];
   assign mode_field = ctc_mode_t'(timer_control_two_q[CTC_MODE_LSB +: 2]);
   assign output_function_field = timer_control_two_q[CTC_IO_LSB +: 2];
   assign output_initial_level = timer_control_two_q[CTC_OC_BIT];
   assign output_invert = timer_control_two_q[CTC_POL_BIT];
   assign period_duty_swap = timer_control_two_q[CTC_SWAP_BIT];
   assign clear_source_select = timer_control_two_q[CTC_CLR_BIT];
   assign is_pwm = mode_field == CTC_MODE_PWM;

   assign on_rise = timer_on & ~on_prev_q;
   assign run = timer_on & ~counter_pause & timer_tick;
   // The clear select bit has no say in PWM, where the swap bit picks which compare clears.
   assign clear_by_a = is_pwm ? period_duty_swap : clear_source_select;
   assign a_evt = run & cif.a_hit;
   assign p_evt = run & (is_pwm | ~clear_source_select)
      & (cif.p_hit | (cif.ovf & (period_compare_bits == 3'h0)));
   assign clear_evt = run & (clear_by_a ? cif.a_hit : cif.p_hit);
   assign per_len = (period_compare_bits == 3'h0) ? CTC_FULL_LEN
      : {1'b0, period_compare_bits, 7'h00};
   assign duty = period_duty_swap ? per_len : {1'b0, cmpa_q};

   assign acc = psel & penable;
   assign wr_fire = acc & pready_q & pwrite;
   assign mapped = ctc_hit(paddr, CTC_ADDR_CTRL1) | ctc_hit(paddr, CTC_ADDR_CTRL2)
      | ctc_hit(paddr, CTC_ADDR_CMPA) | ctc_hit(paddr, CTC_ADDR_CNT)
      | ctc_hit(paddr, CTC_ADDR_FLAG) | ctc_hit(paddr, CTC_ADDR_PINEN);

   always_comb
   begin
      rd_val = 32'h0000_0000;
      case (paddr)
         CTC_ADDR_CTRL1: rd_val[7:0] = ctrl1_q;
         CTC_ADDR_CTRL2: rd_val[7:0] = timer_control_two_q;
         CTC_ADDR_CMPA: rd_val[CTC_CNT_W-1:0] = cmpa_q;
         CTC_ADDR_CNT: rd_val[CTC_CNT_W-1:0] = cnt_q;
         CTC_ADDR_FLAG:
         begin
            rd_val[CTC_FLAG_A_BIT] = flag_a_q;
            rd_val[CTC_FLAG_P_BIT] = flag_p_q;
         end
         CTC_ADDR_PINEN: rd_val[CTC_PINS-1:0] = pinen_q;
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // One wait state: pready rises in the second access cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pready_q <= acc & ~pready_q;
         if (acc & ~pready_q)
         begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr_q <= ~mapped;
         end
         else
         begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl1_q <= CTC_CTRL_RST;
         timer_control_two_q <= CTC_CTRL_RST;
         cmpa_q <= CTC_CMPA_RST;
         pinen_q <= CTC_PINEN_RST;
      end
      else if (wr_fire)
      begin
         if (ctc_hit(paddr, CTC_ADDR_CTRL1))
            ctrl1_q <= pwdata[7:0];
         if (ctc_hit(paddr, CTC_ADDR_CTRL2))
            timer_control_two_q <= pwdata[7:0];
         if (ctc_hit(paddr, CTC_ADDR_CMPA))
            cmpa_q <= pwdata[CTC_CNT_W-1:0];
         if (ctc_hit(paddr, CTC_ADDR_PINEN))
            pinen_q <= pwdata[CTC_PINS-1:0];
      end
   end

   // A hit in the same cycle as a write-one-to-clear keeps the flag set.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag_a_q <= 1'b0;
         flag_p_q <= 1'b0;
      end
      else
      begin
         flag_a_q <= a_evt | (flag_a_q & ~(wr_fire & ctc_hit(paddr, CTC_ADDR_FLAG)
            & pwdata[CTC_FLAG_A_BIT]));
         flag_p_q <= p_evt | (flag_p_q & ~(wr_fire & ctc_hit(paddr, CTC_ADDR_FLAG)
            & pwdata[CTC_FLAG_P_BIT]));
      end
   end

   always_comb
   begin
      cnt_d = cnt_q;
      if (on_rise)
         cnt_d = '0;
      else if (run)
         cnt_d = clear_evt ? '0 : cnt_q + 10'h001;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= '0;
         on_prev_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         on_prev_q <= timer_on;
      end
   end

   always_comb
   begin
      lvl_d = lvl_q;
      if (is_pwm)
      begin
         case (output_function_field)
            CTC_PWM_INACT: lvl_d = ~output_initial_level;
            CTC_PWM_ACT: lvl_d = output_initial_level;
            CTC_PWM_WAVE: lvl_d = ({1'b0, cnt_d} < duty) ? output_initial_level : ~output_initial_level;
            default: lvl_d = lvl_q;
         endcase
      end
      else if (on_rise)
         lvl_d = output_initial_level;
      else if (a_evt && mode_field == CTC_MODE_CMP)
      begin
         // Driving to the level already held leaves the pin as it is.
         case (output_function_field)
            CTC_IO_LOW: lvl_d = 1'b0;
            CTC_IO_HIGH: lvl_d = 1'b1;
            CTC_IO_TOGGLE: lvl_d = ~lvl_q;
            default: lvl_d = lvl_q;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         lvl_q <= 1'b0;
      else
         lvl_q <= lvl_d;
   end

   genvar gi;
   generate
      for (gi = 0; gi < CTC_PINS; gi++)
      begin : g_pin
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               pin_q[gi] <= 1'b0;
            else
               pin_q[gi] <= pinen_q[gi] & ctc_pin_mode(mode_field) & (lvl_d ^ output_invert);
         end
      end
   endgenerate

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign timer_out_pin_zero = pin_q[0];
   assign timer_out_pin_one = pin_q[1];
   assign timer_out_pin_two = pin_q[2];

   a_on_clears_cnt: assert property (@(posedge pclk) disable iff (!presetn)
      on_rise |=> cnt_q == '0)
      else $error("Counter not cleared after timer on rose.");

   a_pause_holds: assert property (@(posedge pclk) disable iff (!presetn)
      (counter_pause && !on_rise) |=> $stable(cnt_q))
      else $error("Counter moved while paused.");

   a_p_flag_blocked: assert property (@(posedge pclk) disable iff (!presetn)
      (!is_pwm && clear_source_select && !flag_p_q) |=> !flag_p_q)
      else $error("P flag raised with compare A clear selected.");

   a_a_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
      (run && cif.a_hit) |=> flag_a_q)
      else $error("A flag missing after compare A match.");

   a_period_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (run && !on_rise && !clear_by_a && cif.p_hit) |=> cnt_q == '0)
      else $error("Counter not cleared on period match.");

   a_zero_cmpa_ovf: assert property (@(posedge pclk) disable iff (!presetn)
      (run && cnt_q == CTC_CNT_MAX && cmpa_q == '0) |-> !a_evt ##1 cnt_q == '0)
      else $error("Compare A zero misbehaved at overflow.");

   a_toggle_pin: assert property (@(posedge pclk) disable iff (!presetn)
      (a_evt && !on_rise && mode_field == CTC_MODE_CMP && output_function_field == CTC_IO_TOGGLE)
      |=> lvl_q != $past(lvl_q))
      else $error("Output did not toggle on compare A match.");

   a_p_no_pin: assert property (@(posedge pclk) disable iff (!presetn)
      (p_evt && !a_evt && !on_rise && mode_field == CTC_MODE_CMP) |=> $stable(lvl_q))
      else $error("Period match moved the output.");

   a_init_level: assert property (@(posedge pclk) disable iff (!presetn)
      (on_rise && mode_field == CTC_MODE_CMP) |=> lvl_q == $past(output_initial_level))
      else $error("Output not restored to initial level.");

   a_pin_invert: assert property (@(posedge pclk) disable iff (!presetn)
      (pinen_q[0] && ctc_pin_mode(mode_field)) |=> timer_out_pin_zero == (lvl_q ^ $past(output_invert)))
      else $error("Pin polarity wrong.");

   a_tc_pin_low: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_field == CTC_MODE_TC) |=> pin_q == '0)
      else $error("Pins driven in timer mode.");
endmodule

// ==== bench/ctc_pin_load.sv ====
// External load model that reports the levels on the three timer output pins.
`timescale 1ns/1ns
module ctc_pin_load
(
   input wire logic pin_zero,
   input wire logic pin_one,
   input wire logic pin_two,
   output logic [2:0] level
);
   assign level = {pin_two, pin_one, pin_zero};
endmodule

// ==== bench/tb_compact_timer_compare_core.sv ====
// Self-checking bench for the compact timer compare core.
`timescale 1ns/1ns
module tb_compact_timer_compare_core;
   import ctc_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic timer_tick = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, p0, p1, p2;
   logic [2:0] pins;
   logic [31:0] q;
   logic e;
   int num_errors = 0;
   int checked = 0;
   int cyc = 0;
   always #5 pclk = ~pclk;
   ctc_top ctc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_tick(timer_tick), .timer_out_pin_zero(p0), .timer_out_pin_one(p1), .timer_out_pin_two(p2));
   ctc_pin_load ctc_pin_load_inst (.pin_zero(p0), .pin_one(p1), .pin_two(p2), .level(pins));
   task automatic results();
      $display("counts: %0d checks, %0d mismatches", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] y);
      checked++;
      if (x !== y)
      begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", n, x, y);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      cmp("write error", 32'h0, {31'h0, e});
   endtask
   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
      bus(1'b0, a, 32'h0);
      cmp(n, x, q);
   endtask
   task automatic ticks(input int n);
      repeat (n)
      begin
         timer_tick <= 1'b1;
         @(posedge pclk);
      end
      timer_tick <= 1'b0;
      @(posedge pclk);
   endtask
   // Configures while off, turns on, ticks, then checks count, flags, pins, pause and stop.
   task automatic run(input logic [7:0] c1, c2, input logic [9:0] a, input logic [2:0] en, input int n,
      input logic [9:0] cnt, input logic [1:0] flg, input logic s, f);
      wr(CTC_ADDR_CTRL1, 32'h0);
      wr(CTC_ADDR_CTRL2, {24'h0, c2});
      wr(CTC_ADDR_CMPA, {22'h0, a});
      wr(CTC_ADDR_PINEN, {29'h0, en});
      wr(CTC_ADDR_FLAG, 32'h3);
      wr(CTC_ADDR_CTRL1, {24'h0, c1});
      @(posedge pclk);
      cmp("pins at start", {29'h0, en & {3{s}}}, {29'h0, pins});
      ticks(n);
      rd("counter", CTC_ADDR_CNT, {22'h0, cnt});
      rd("flags", CTC_ADDR_FLAG, {30'h0, flg});
      cmp("pins at end", {29'h0, en & {3{f}}}, {29'h0, pins});
      wr(CTC_ADDR_CTRL1, {24'h0, c1 | 8'h80});
      ticks(3);
      rd("paused counter", CTC_ADDR_CNT, {22'h0, cnt});
      wr(CTC_ADDR_CTRL1, 32'h0);
      ticks(2);
      rd("stopped counter", CTC_ADDR_CNT, {22'h0, cnt});
      $display("test done: mode %h, %0d ticks", c2, n);
   endtask
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         num_errors++;
         $display("unexpected timeout at cycle %0d", cyc);
         results();
      end
   end
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd("control one", CTC_ADDR_CTRL1, 32'h0);
      rd("control two", CTC_ADDR_CTRL2, 32'h0);
      rd("compare a", CTC_ADDR_CMPA, 32'h0);
      rd("pin enables", CTC_ADDR_PINEN, 32'h0);
      wr(CTC_ADDR_CTRL2, 32'hffffffa5);
      rd("control two", CTC_ADDR_CTRL2, 32'ha5);
      wr(CTC_ADDR_CNT, 32'h3ff);
      rd("counter", CTC_ADDR_CNT, 32'h0);
      bus(1'b0, 8'h20, 32'h0);
      cmp("unmapped error", 32'h1, {31'h0, e});
      cmp("unmapped data", 32'h0, q);
      $display("test done: registers");
      run(8'h09, 8'h31, 10'h005, 3'h7, 5, 10'h000, 2'h1, 1'h0, 1'h1);
      run(8'h09, 8'h31, 10'h005, 3'h7, 10, 10'h000, 2'h1, 1'h0, 1'h0);
      run(8'h09, 8'h30, 10'h005, 3'h7, 128, 10'h000, 2'h3, 1'h0, 1'h1);
      run(8'h09, 8'h30, 10'h005, 3'h7, 127, 10'h07f, 2'h1, 1'h0, 1'h1);
      run(8'h0f, 8'h00, 10'h000, 3'h7, 896, 10'h000, 2'h2, 1'h0, 1'h0);
      run(8'h08, 8'h00, 10'h000, 3'h7, 1023, 10'h3ff, 2'h0, 1'h0, 1'h0);
      run(8'h08, 8'h00, 10'h000, 3'h7, 1024, 10'h000, 2'h2, 1'h0, 1'h0);
      run(8'h08, 8'h01, 10'h000, 3'h7, 1024, 10'h000, 2'h0, 1'h0, 1'h0);
      run(8'h09, 8'h31, 10'h0c8, 3'h7, 200, 10'h000, 2'h1, 1'h0, 1'h1);
      run(8'h09, 8'h11, 10'h003, 3'h7, 3, 10'h000, 2'h1, 1'h0, 1'h0);
      run(8'h09, 8'h19, 10'h003, 3'h7, 3, 10'h000, 2'h1, 1'h1, 1'h0);
      run(8'h09, 8'h29, 10'h003, 3'h7, 3, 10'h000, 2'h1, 1'h1, 1'h1);
      run(8'h09, 8'h21, 10'h003, 3'h7, 3, 10'h000, 2'h1, 1'h0, 1'h1);
      run(8'h09, 8'h35, 10'h003, 3'h5, 3, 10'h000, 2'h1, 1'h1, 1'h0);
      run(8'h09, 8'hf9, 10'h003, 3'h0, 3, 10'h000, 2'h1, 1'h0, 1'h0);
      run(8'h09, 8'h71, 10'h003, 3'h7, 3, 10'h000, 2'h1, 1'h0, 1'h0);
      run(8'h09, 8'h88, 10'h000, 3'h7, 3, 10'h003, 2'h0, 1'h0, 1'h0);
      run(8'h09, 8'h98, 10'h000, 3'h7, 3, 10'h003, 2'h0, 1'h1, 1'h1);
      run(8'h09, 8'ha8, 10'h040, 3'h7, 70, 10'h046, 2'h1, 1'h1, 1'h0);
      run(8'h09, 8'haa, 10'h0c8, 3'h7, 150, 10'h096, 2'h2, 1'h1, 1'h0);
      wr(CTC_ADDR_CTRL1, 32'h09);
      ticks(2);
      wr(CTC_ADDR_CTRL1, 32'h89);
      ticks(3);
      wr(CTC_ADDR_CTRL1, 32'h09);
      ticks(2);
      rd("resumed counter", CTC_ADDR_CNT, 32'h4);
      $display("test done: pause and resume");
      results();
   end
endmodule
